/* File: common/tcc_pkg.sv */
// constants, field layout and mode type of the 16-bit capture/compare timer
// assumes one system clock and a simple byte/halfword cpu register port
//
// Functional notes
// RULE1 - register A captures on chosen input B edge
// RULE2 - edge-select code 10 never programmed by software
// RULE3 - edge select B bits 7:6, A bits 5:4
// RULE4 - register A written whole, not reset
// RULE5 - A equal zero matches on 0000 to 0001 after wrap
// RULE6 - software keeps A nonzero in match-clear mode
// RULE7 - lowered compare value matches only after wrap
// RULE8 - capture from input A raises no interrupt
// RULE9 - register B compare raises match B interrupt
// RULE10 - control bit 2 selects register B capture
// RULE11 - register B captures on input A valid edge
// RULE12 - mode 00 stops, clears counter, no interrupts
// RULE13 - mode 01 free, 10 edge-clear, 11 match-clear
// RULE14 - mode bit 1 adds input A edge toggle
// RULE15 - running modes interrupt on A or B match
// RULE16 - bit 0 overflow flag, also in match-clear wrap
// RULE17 - only overflow flag written while timer runs
// RULE18 - control bit 1 picks register A capture source
// RULE19 - control bit 0 selects register A capture
// RULE20 - both-edges input A gives no A capture
// RULE21 - no A capture while match-clear mode selected
// RULE22 - no input A count clock with B capture
// RULE23 - control register written only while stopped
// RULE24 - counter steps on tick, cpu read pauses it
// RULE25 - clock select: div2, div4, div64, input A
// RULE26 - events on count clock, interrupts single pulses

package tcc_pkg;

    // register addresses
    localparam logic [15:0] ADDR_TMC = 16'hFF78;
    localparam logic [15:0] ADDR_PRM = 16'hFF7A;
    localparam logic [15:0] ADDR_CRC = 16'hFF7C;
    localparam logic [15:0] ADDR_CNT = 16'hFF70;
    localparam logic [15:0] ADDR_CRA = 16'hFF72;
    localparam logic [15:0] ADDR_CRB = 16'hFF74;

    // field positions
    localparam int TMC_OVF_BIT = 0;
    localparam int TMC_TOG_BIT = 1;
    localparam int TMC_MODE_LSB = 2;
    localparam int CRC_A_CAP_BIT = 0;
    localparam int CRC_A_SRC_BIT = 1;
    localparam int CRC_B_CAP_BIT = 2;
    localparam int PRM_CLK_LSB = 0;
    localparam int PRM_ES_A_LSB = 4;
    localparam int PRM_ES_B_LSB = 6;

    // reset values
    localparam logic [7:0] TMC_RESET = 8'h00;
    localparam logic [7:0] CRC_RESET = 8'h00;
    localparam logic [7:0] PRM_RESET = 8'h00;

    // edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // count clock select codes and divider masks
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV64 = 2'h2;
    localparam logic [1:0] CLK_PIN_A = 2'h3;
    localparam logic [5:0] DIV2_MASK = 6'h01;
    localparam logic [5:0] DIV4_MASK = 6'h03;
    localparam logic [5:0] DIV64_MASK = 6'h3F;

    typedef enum logic [1:0] {
        TCC_STOP,
        TCC_FREE,
        TCC_EDGE_CLR,
        TCC_MATCH_CLR
    } tcc_mode_t;

endpackage

/* File: src/tcc_edge_detect.sv */
// edge finder for one trigger input with a selectable valid edge
// assumes the pin is already synchronous to clk_sys
`timescale 1ns/1ps

module tcc_edge_detect (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // pin and edge choice
    input wire logic pin,
    input wire logic [1:0] edge_sel,
    // detected edges
    output logic valid_edge,
    output logic reverse_edge
);

    typedef struct packed {
        logic prev;
    } tcc_edge_state_t;

    tcc_edge_state_t st_reg;
    tcc_edge_state_t st_next;
    logic rise;
    logic fall;

    assign rise = pin && !st_reg.prev;
    assign fall = !pin && st_reg.prev;

    always_comb begin
        st_next.prev = pin;
        valid_edge = 1'b0;
        reverse_edge = 1'b0;
        unique case (edge_sel)
            tcc_pkg::EDGE_FALL: begin
                valid_edge = fall;
                reverse_edge = rise;
            end
            tcc_pkg::EDGE_RISE: begin
                valid_edge = rise;
                reverse_edge = fall;
            end
            // no reverse edge exists when both edges are valid [RULE20]
            tcc_pkg::EDGE_BOTH: begin
                valid_edge = rise || fall;
                reverse_edge = 1'b0;
            end
            // prohibited code: no edge at all [RULE2]
            default: begin
                valid_edge = 1'b0;
                reverse_edge = 1'b0;
            end
        endcase
    end

    // reset low: a pin high after reset shows a rising edge once
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

/* File: src/tcc_timer.sv */
// 16-bit up-counter with two capture/compare registers and cpu port
// assumes cpu strobes and trigger pins synchronous to clk_sys
`timescale 1ns/1ps

module tcc_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // cpu register port
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [15:0] cpu_rdata,
    // trigger pins
    input wire logic trigger_input_a,
    input wire logic trigger_input_b,
    // timer output and interrupts
    output logic timer_output_pin,
    output logic match_irq_a,
    output logic match_irq_b
);

    generate
        if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
            $error("tcc_timer: CNT_W must lie in 2..16");
        end
    endgenerate

    typedef struct packed {
        tcc_pkg::tcc_mode_t mode;
        logic tog_sel;
        logic ovf;
        logic [2:0] crc;
        logic [7:0] prm;
        logic [CNT_W-1:0] cnt;
        logic wrapped;
        logic [5:0] div;
        logic out;
        logic irq_a;
        logic irq_b;
        logic [15:0] rdata;
    } tcc_state_t;

    typedef struct packed {
        logic [CNT_W-1:0] cr_a;
        logic [CNT_W-1:0] cr_b;
    } tcc_data_t;

    tcc_state_t st_reg;
    tcc_state_t st_next;
    tcc_data_t dat_reg;
    tcc_data_t dat_next;

    logic a_valid;
    logic a_rev;
    logic b_valid;
    logic running;
    logic base_tick;
    logic cnt_read;
    logic tick;
    logic hit_a;
    logic hit_b;
    logic ovf_hit;
    logic cap_a_from_b;
    logic cap_a_from_a;
    logic cap_b;
    logic edge_clr;
    logic toggle;
    logic [15:0] rd_word;

    // edge select fields of the prescaler register [RULE3]
    tcc_edge_detect u_edge_a (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(trigger_input_a),
        .edge_sel(st_reg.prm[tcc_pkg::PRM_ES_A_LSB +: 2]),
        .valid_edge(a_valid),
        .reverse_edge(a_rev)
    );

    tcc_edge_detect u_edge_b (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pin(trigger_input_b),
        .edge_sel(st_reg.prm[tcc_pkg::PRM_ES_B_LSB +: 2]),
        .valid_edge(b_valid),
        .reverse_edge()
    );

    assign running = st_reg.mode != tcc_pkg::TCC_STOP;

    // count clock source [RULE25]
    always_comb begin
        base_tick = 1'b0;
        unique case (st_reg.prm[tcc_pkg::PRM_CLK_LSB +: 2])
            tcc_pkg::CLK_DIV2: begin
                base_tick = (st_reg.div & tcc_pkg::DIV2_MASK) == tcc_pkg::DIV2_MASK;
            end
            tcc_pkg::CLK_DIV4: begin
                base_tick = (st_reg.div & tcc_pkg::DIV4_MASK) == tcc_pkg::DIV4_MASK;
            end
            tcc_pkg::CLK_DIV64: begin
                base_tick = (st_reg.div & tcc_pkg::DIV64_MASK) == tcc_pkg::DIV64_MASK;
            end
            tcc_pkg::CLK_PIN_A: begin
                base_tick = a_valid;
            end
        endcase
    end

    // a counter read swallows that tick so the value stays put [RULE24]
    assign cnt_read = cpu_rd && (cpu_addr == tcc_pkg::ADDR_CNT);
    assign tick = running && base_tick && !cnt_read;

    // match on the tick that leaves the compare value; zero waits for a wrap
    assign hit_a = tick && !st_reg.crc[tcc_pkg::CRC_A_CAP_BIT]
        && (st_reg.cnt == dat_reg.cr_a)
        && ((dat_reg.cr_a != '0) || st_reg.wrapped); // [RULE5] [RULE7] [RULE15]
    assign hit_b = tick && !st_reg.crc[tcc_pkg::CRC_B_CAP_BIT]
        && (st_reg.cnt == dat_reg.cr_b)
        && ((dat_reg.cr_b != '0) || st_reg.wrapped); // [RULE9] [RULE15]
    assign ovf_hit = tick && (st_reg.cnt == '1); // [RULE16]

    // capture sources [RULE1] [RULE18] [RULE19] [RULE10] [RULE11]
    assign cap_a_from_b = running && st_reg.crc[tcc_pkg::CRC_A_CAP_BIT]
        && !st_reg.crc[tcc_pkg::CRC_A_SRC_BIT] && b_valid;
    assign cap_a_from_a = running && st_reg.crc[tcc_pkg::CRC_A_CAP_BIT]
        && st_reg.crc[tcc_pkg::CRC_A_SRC_BIT] && a_rev; // [RULE20]
    assign cap_b = running && st_reg.crc[tcc_pkg::CRC_B_CAP_BIT] && a_valid;

    assign edge_clr = (st_reg.mode == tcc_pkg::TCC_EDGE_CLR) && a_valid; // [RULE13]
    assign toggle = hit_a || hit_b || (running && st_reg.tog_sel && a_valid); // [RULE14]

    always_comb begin
        rd_word = 16'h0000;
        if (cpu_addr == tcc_pkg::ADDR_TMC) begin
            rd_word[tcc_pkg::TMC_OVF_BIT] = st_reg.ovf;
            rd_word[tcc_pkg::TMC_TOG_BIT] = st_reg.tog_sel;
            rd_word[tcc_pkg::TMC_MODE_LSB +: 2] = st_reg.mode;
        end else if (cpu_addr == tcc_pkg::ADDR_CRC) begin
            rd_word[2:0] = st_reg.crc;
        end else if (cpu_addr == tcc_pkg::ADDR_PRM) begin
            rd_word[7:0] = st_reg.prm & 8'hF3;
        end else if (cpu_addr == tcc_pkg::ADDR_CNT) begin
            rd_word = 16'(st_reg.cnt);
        end else if (cpu_addr == tcc_pkg::ADDR_CRA) begin
            rd_word = 16'(dat_reg.cr_a);
        end else if (cpu_addr == tcc_pkg::ADDR_CRB) begin
            rd_word = 16'(dat_reg.cr_b);
        end
    end

    always_comb begin
        st_next = st_reg;
        dat_next = dat_reg;
        st_next.irq_a = 1'b0;
        st_next.irq_b = 1'b0;
        if (cpu_rd) begin
            st_next.rdata = rd_word;
        end
        // cpu writes; a hardware event below overrides them
        if (cpu_wr) begin
            if (cpu_addr == tcc_pkg::ADDR_TMC) begin
                st_next.ovf = cpu_wdata[tcc_pkg::TMC_OVF_BIT];
                st_next.tog_sel = cpu_wdata[tcc_pkg::TMC_TOG_BIT];
                st_next.mode = tcc_pkg::tcc_mode_t'(cpu_wdata[tcc_pkg::TMC_MODE_LSB +: 2]);
            end
            if (cpu_addr == tcc_pkg::ADDR_CRC) begin
                st_next.crc = cpu_wdata[2:0];
            end
            if (cpu_addr == tcc_pkg::ADDR_PRM) begin
                st_next.prm = cpu_wdata[7:0] & 8'hF3;
            end
            // one full-width write only [RULE4]
            if (cpu_addr == tcc_pkg::ADDR_CRA) begin
                dat_next.cr_a = cpu_wdata[CNT_W-1:0];
            end
            if (cpu_addr == tcc_pkg::ADDR_CRB) begin
                dat_next.cr_b = cpu_wdata[CNT_W-1:0];
            end
        end
        if (!running) begin
            // stopped: counter held at zero, nothing fires [RULE12]
            st_next.cnt = '0;
            st_next.wrapped = 1'b0;
            st_next.div = 6'h00;
        end else begin
            st_next.div = st_reg.div + 6'h01;
            if (edge_clr) begin
                st_next.cnt = '0;
            end else if (tick) begin
                if ((st_reg.mode == tcc_pkg::TCC_MATCH_CLR)
                    && !st_reg.crc[tcc_pkg::CRC_A_CAP_BIT]
                    && (st_reg.cnt == dat_reg.cr_a)) begin
                    st_next.cnt = '0; // [RULE13]
                end else begin
                    st_next.cnt = st_reg.cnt + 1'b1; // [RULE24]
                end
            end
            // set wins over a same-cycle software clear [RULE16]
            if (ovf_hit) begin
                st_next.ovf = 1'b1;
                st_next.wrapped = 1'b1;
            end
            if (cap_a_from_b || cap_a_from_a) begin
                dat_next.cr_a = st_reg.cnt; // [RULE1] [RULE18]
            end
            if (cap_b) begin
                dat_next.cr_b = st_reg.cnt; // [RULE11]
            end
            // register A capture from input A stays silent [RULE8] [RULE26]
            st_next.irq_a = hit_a || cap_a_from_b;
            st_next.irq_b = hit_b || cap_b;
            if (toggle) begin
                st_next.out = !st_reg.out; // [RULE14]
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.mode <= tcc_pkg::tcc_mode_t'(tcc_pkg::TMC_RESET[tcc_pkg::TMC_MODE_LSB +: 2]);
            st_reg.crc <= tcc_pkg::CRC_RESET[2:0];
            st_reg.prm <= tcc_pkg::PRM_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // compare/capture contents are left undefined by reset [RULE4]
    always_ff @(posedge clk_sys) begin
        dat_reg <= dat_next;
    end

    assign cpu_rdata = st_reg.rdata;
    assign timer_output_pin = st_reg.out;
    assign match_irq_a = st_reg.irq_a;
    assign match_irq_b = st_reg.irq_b;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    chk_stop_quiet: assert property ( // [RULE12]
        (st_reg.mode == tcc_pkg::TCC_STOP) [*2]
        |-> !match_irq_a && !match_irq_b && (st_reg.cnt == '0))
    else $error("stopped timer counts or interrupts");

    chk_ovf_sets: assert property ( // [RULE16]
        (tick && (st_reg.cnt == '1)) |=> st_reg.ovf && (st_reg.cnt == '0))
    else $error("wrap did not set overflow flag");

    chk_match_a_irq: assert property ( // [RULE15]
        (tick && !st_reg.crc[tcc_pkg::CRC_A_CAP_BIT] && (dat_reg.cr_a != '0)
         && (st_reg.cnt == dat_reg.cr_a)) |=> match_irq_a)
    else $error("match A gave no interrupt");

    chk_match_b_irq: assert property ( // [RULE9]
        (tick && !st_reg.crc[tcc_pkg::CRC_B_CAP_BIT] && (dat_reg.cr_b != '0)
         && (st_reg.cnt == dat_reg.cr_b)) |=> match_irq_b ##1 !match_irq_b)
    else $error("match B interrupt missing or not a pulse");

    chk_cap_a_quiet: assert property ( // [RULE8]
        (cap_a_from_a && !b_valid) |=> !match_irq_a)
    else $error("input A capture raised interrupt");

    chk_cap_b_latch: assert property ( // [RULE11]
        cap_b |=> (dat_reg.cr_b == $past(st_reg.cnt)) && match_irq_b)
    else $error("register B did not capture counter");

    chk_both_no_cap: assert property ( // [RULE20]
        (running && st_reg.crc[tcc_pkg::CRC_A_SRC_BIT]
         && (st_reg.prm[tcc_pkg::PRM_ES_A_LSB +: 2] == tcc_pkg::EDGE_BOTH)
         && !(cpu_wr && (cpu_addr == tcc_pkg::ADDR_CRA)))
        |=> $stable(dat_reg.cr_a))
    else $error("both-edge input A captured into A");

    chk_match_clear: assert property ( // [RULE13]
        (tick && (st_reg.mode == tcc_pkg::TCC_MATCH_CLR) && !edge_clr
         && !st_reg.crc[tcc_pkg::CRC_A_CAP_BIT] && (st_reg.cnt == dat_reg.cr_a))
        |=> (st_reg.cnt == '0))
    else $error("match did not clear counter");

    chk_zero_waits: assert property ( // [RULE5]
        (tick && (dat_reg.cr_a == '0) && !st_reg.wrapped && (st_reg.cnt == '0))
        |=> !match_irq_a || $past(cap_a_from_b))
    else $error("zero compare fired before wrap");

    chk_read_hold: assert property ( // [RULE24]
        (cnt_read && running && (st_reg.mode != tcc_pkg::TCC_EDGE_CLR)
         && !(cpu_wr && (cpu_addr == tcc_pkg::ADDR_TMC)))
        |=> $stable(st_reg.cnt) && (cpu_rdata == 16'($past(st_reg.cnt))))
    else $error("counter moved during read");

    chk_toggle_out: assert property ( // [RULE14]
        toggle |=> (timer_output_pin != $past(timer_output_pin)))
    else $error("output did not toggle");

    chk_ovf_sticky: assert property ( // [RULE16]
        (st_reg.ovf && !(cpu_wr && (cpu_addr == tcc_pkg::ADDR_TMC))) |=> st_reg.ovf)
    else $error("overflow flag dropped without a write");

    chk_cap_a_latch: assert property ( // [RULE1]
        cap_a_from_b |=> (dat_reg.cr_a == $past(st_reg.cnt)) && match_irq_a)
    else $error("register A did not capture on input B");

    chk_rev_cap_a: assert property ( // [RULE18]
        cap_a_from_a |=> (dat_reg.cr_a == $past(st_reg.cnt)) && !match_irq_a)
    else $error("reverse edge capture into A wrong");

    chk_edge_clear: assert property ( // [RULE13]
        edge_clr |=> (st_reg.cnt == '0))
    else $error("input A edge did not clear counter");

    chk_zero_after_wrap: assert property ( // [RULE5]
        (tick && !st_reg.crc[tcc_pkg::CRC_A_CAP_BIT] && (dat_reg.cr_a == '0)
         && st_reg.wrapped && (st_reg.cnt == '0)) |=> match_irq_a)
    else $error("zero compare missed after wrap");

    chk_stop_clears: assert property ( // [RULE12]
        !running |=> (st_reg.cnt == '0) && (st_reg.div == 6'h00))
    else $error("stopped timer kept a count");

    chk_irq_a_pulse: assert property ( // [RULE26]
        hit_a |=> match_irq_a ##1 !match_irq_a)
    else $error("match A interrupt not a single pulse");

    chk_mode_readback: assert property ( // [RULE16]
        (cpu_rd && (cpu_addr == tcc_pkg::ADDR_TMC))
        |=> (cpu_rdata[15:4] == 12'h000) && (cpu_rdata[3:0] == {$past(st_reg.mode),
            $past(st_reg.tog_sel), $past(st_reg.ovf)}))
    else $error("mode register read back wrong");

    cov_overflow: cover property (ovf_hit ##1 st_reg.ovf);
    cov_pin_clock: cover property (tick && (st_reg.prm[1:0] == tcc_pkg::CLK_PIN_A));
    cov_cap_a_b: cover property (cap_a_from_b ##1 match_irq_a);
    cov_match_b: cover property (hit_b ##1 match_irq_b);
    cov_edge_clr: cover property (edge_clr ##1 (st_reg.cnt == '0));

endmodule

/* File: verification/tcc_trigger_model.sv */
// far-side model: drives the two trigger pins as clean synchronous pulses
// assumes the bench calls pulse() from its own sequence, one pulse at a time
`timescale 1ns/1ps

module tcc_trigger_model (
    // clock
    input wire logic clk_sys,
    // trigger pins
    output logic trig_a,
    output logic trig_b
);
    initial begin
        trig_a = 1'b0;
        trig_b = 1'b0;
    end

    // each level held 8 cycles: wider than two count-clock periods at /2
    task automatic pulse(input bit sel_b);
        @(negedge clk_sys);
        if (sel_b) trig_b = 1'b1; else trig_a = 1'b1;
        repeat (8) @(negedge clk_sys);
        if (sel_b) trig_b = 1'b0; else trig_a = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

/* File: verification/tcc_timer_tb.sv */
// self-checking bench for the capture/compare timer, counter cut to 8 bits
// assumes the cpu port contract: one-cycle strobes, read data one cycle later
`timescale 1ns/1ps

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end

module tcc_timer_tb;
    logic clk_sys = 1'b0;
    logic rst_b;
    logic [15:0] cpu_addr;
    logic [15:0] cpu_wdata;
    logic cpu_wr;
    logic cpu_rd;
    logic [15:0] cpu_rdata;
    logic trig_a, trig_b, pin, irq_a, irq_b;
    int n_fail = 0;
    int n_tests = 0;
    int n_irq_a = 0;
    int n_irq_b = 0;
    int cycles = 0;
    int base;
    logic [15:0] v;
    logic p0;
    logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
    int exp_edges [3] = '{1, 1, 2};
    int divs [3] = '{2, 4, 64};
    // count held at the chosen input B edge: rise at count 0, fall at count 4
    logic [15:0] exp_cap [3] = '{16'h0004, 16'h0000, 16'h0004};

    always #10 clk_sys = ~clk_sys;

    tcc_timer #(.CNT_W(8)) tcc_timer_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .trigger_input_a(trig_a), .trigger_input_b(trig_b),
        .timer_output_pin(pin), .match_irq_a(irq_a), .match_irq_b(irq_b)
    );

    tcc_trigger_model tcc_trigger_model_inst (
        .clk_sys(clk_sys), .trig_a(trig_a), .trig_b(trig_b)
    );

    always @(posedge clk_sys) begin
        cycles++;
        if (irq_a === 1'b1) n_irq_a++;
        if (irq_b === 1'b1) n_irq_b++;
        if (cycles == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk_sys);
        cpu_wr = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk_sys);
        cpu_rd = 1'b0;
        d = cpu_rdata;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // software keeps to stop-before-reconfigure in every step below
    task automatic setup(input logic [7:0] crc, input logic [7:0] prm, input logic [7:0] tmc);
        wr(tcc_pkg::ADDR_TMC, 16'h0000);
        wr(tcc_pkg::ADDR_CRC, {8'h00, crc});
        wr(tcc_pkg::ADDR_PRM, {8'h00, prm});
        wr(tcc_pkg::ADDR_TMC, {8'h00, tmc});
    endtask

    task automatic stop_test();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'b0;
        cpu_addr = 16'h0000;
        cpu_wdata = 16'h0000;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        rd(tcc_pkg::ADDR_TMC, v); `CHK(v, 16'h0000)
        rd(tcc_pkg::ADDR_CRC, v); `CHK(v, 16'h0000)
        rd(tcc_pkg::ADDR_PRM, v); `CHK(v, 16'h0000)
        rd(16'hFF7E, v); `CHK(v, 16'h0000)
        wr(tcc_pkg::ADDR_CRC, 16'h00FF);
        rd(tcc_pkg::ADDR_CRC, v); `CHK(v, 16'h0007)
        wr(tcc_pkg::ADDR_PRM, 16'h00FF);
        rd(tcc_pkg::ADDR_PRM, v); `CHK(v, 16'h00F3)
        wr(tcc_pkg::ADDR_CNT, 16'h0055);
        rd(tcc_pkg::ADDR_CNT, v); `CHK(v, 16'h0000)
        $display("test registers done");

        wr(tcc_pkg::ADDR_CRA, 16'h0002);
        wr(tcc_pkg::ADDR_CRB, 16'h0040);
        setup(8'h00, 8'h00, 8'h04);
        idle(30);
        `CHK(n_irq_a, 1)
        `CHK(n_irq_b, 0)
        `CHK(pin, 1'b1)
        idle(120);
        `CHK(n_irq_b, 1)
        `CHK(pin, 1'b0)
        wr(tcc_pkg::ADDR_CRA, 16'h0000);
        idle(100);
        `CHK(n_irq_a, 1)
        wr(tcc_pkg::ADDR_TMC, 16'h0000);
        rd(tcc_pkg::ADDR_CNT, v); `CHK(v, 16'h0000)
        base = n_irq_a + n_irq_b;
        idle(100);
        `CHK(n_irq_a + n_irq_b, base)
        $display("test compare done");

        setup(8'h00, 8'h00, 8'h04);
        base = n_irq_a;
        idle(200);
        `CHK(n_irq_a, base)
        idle(400);
        `CHK(n_irq_a, base + 1)
        rd(tcc_pkg::ADDR_TMC, v); `CHK(v, 16'h0005)
        wr(tcc_pkg::ADDR_TMC, 16'h0004);
        rd(tcc_pkg::ADDR_TMC, v); `CHK(v, 16'h0004)
        $display("test wrap done");

        wr(tcc_pkg::ADDR_CRA, 16'h0003);
        setup(8'h00, 8'h00, 8'h0C);
        for (int i = 0; i < 8; i++) begin
            rd(tcc_pkg::ADDR_CNT, v); `CHK(v <= 16'h0003, 1'b1)
        end
        wr(tcc_pkg::ADDR_CRA, 16'h00FF);
        setup(8'h00, 8'h00, 8'h0C);
        idle(600);
        rd(tcc_pkg::ADDR_TMC, v); `CHK(v, 16'h000D)
        $display("test match clear done");

        for (int i = 0; i < 3; i++) begin
            setup(8'h00, {6'h00, 2'(i)}, 8'h04);
            idle(200);
            rd(tcc_pkg::ADDR_CNT, v);
            base = 200 / divs[i];
            `CHK((v + 16'h0003 >= 16'(base)) && (v <= 16'(base)), 1'b1)
        end
        // input A rising edges as count clock: two pulses, two counts
        setup(8'h00, 8'h13, 8'h04);
        tcc_trigger_model_inst.pulse(1'b0);
        tcc_trigger_model_inst.pulse(1'b0);
        rd(tcc_pkg::ADDR_CNT, v); `CHK(v, 16'h0002)
        $display("test clock select done");

        for (int i = 0; i < 3; i++) begin
            wr(tcc_pkg::ADDR_CRA, 16'h1234);
            setup(8'h01, {codes[i], 6'h00}, 8'h04);
            base = n_irq_a;
            tcc_trigger_model_inst.pulse(1'b1);
            idle(2);
            `CHK(n_irq_a - base, exp_edges[i])
            rd(tcc_pkg::ADDR_CRA, v); `CHK(v, exp_cap[i])
            setup(8'h04, {2'h0, codes[i], 4'h0}, 8'h04);
            base = n_irq_b;
            tcc_trigger_model_inst.pulse(1'b0);
            idle(2);
            `CHK(n_irq_b - base, exp_edges[i])
        end
        wr(tcc_pkg::ADDR_CRA, 16'h1234);
        setup(8'h03, 8'h10, 8'h04);
        base = n_irq_a;
        tcc_trigger_model_inst.pulse(1'b0);
        `CHK(n_irq_a, base)
        rd(tcc_pkg::ADDR_CRA, v); `CHK(v, 16'h0004)
        wr(tcc_pkg::ADDR_CRA, 16'h1234);
        setup(8'h03, 8'h30, 8'h04);
        tcc_trigger_model_inst.pulse(1'b0);
        rd(tcc_pkg::ADDR_CRA, v); `CHK(v, 16'h0034)
        $display("test capture done");

        wr(tcc_pkg::ADDR_CRA, 16'h00F0);
        wr(tcc_pkg::ADDR_CRB, 16'h00F0);
        setup(8'h00, 8'h10, 8'h06);
        p0 = pin;
        tcc_trigger_model_inst.pulse(1'b0);
        `CHK(pin, ~p0)
        setup(8'h00, 8'h10, 8'h04);
        tcc_trigger_model_inst.pulse(1'b0);
        `CHK(pin, ~p0)
        setup(8'h00, 8'h10, 8'h08);
        idle(100);
        tcc_trigger_model_inst.pulse(1'b0);
        rd(tcc_pkg::ADDR_CNT, v); `CHK(v < 16'h0010, 1'b1)
        $display("test toggle and edge clear done");
        stop_test();
    end
endmodule
